// ===== hdl/tmsc_host_end.sv
// Host controller: AXI4-Lite registers driving the three-wire port and straps.
// Assumes one AXI4-Lite master on core_clk; the lock pin is asynchronous.
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`default_nettype none

module tmsc_host_end #(
	parameter int HALF_CYC = tmsc_pkg::SCLK_HALF_CYC
) (
	input wire logic core_clk,
	input wire logic reset,
	tmsc_link_if.host link,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	typedef enum logic [4:0] {
		S_IDLE = 5'b00001,
		S_LOW = 5'b00010,
		S_HIGH = 5'b00100,
		S_LOAD = 5'b01000,
		S_HOLD = 5'b10000
	} tmsc_ser_type;

	tmsc_ser_type state_reg;
	logic awHeld_reg;
	logic wHeld_reg;
	logic [3:0] awAddr_reg;
	logic [31:0] wData_reg;
	logic [3:0] wStrb_reg;
	logic [7:0] pins_reg;
	logic [23:0] word_reg;
	logic [4:0] bitIdx_reg;
	logic [15:0] divCnt_reg;
	logic start;
	logic tick;
	logic busy;
	logic programmed_reg;
	logic serSclk_reg;
	logic serData_reg;
	logic serStrobe_reg;
	logic lockMeta_reg;
	logic lockSync_reg;

	function automatic logic tmsc_mapped(input logic [3:0] a);
		return a == tmsc_pkg::OFS_WORD || a == tmsc_pkg::OFS_STATUS || a == tmsc_pkg::OFS_PINS;
	endfunction : tmsc_mapped

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write path: address and data taken in either order
	assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
	assign s_axi_wready = !wHeld_reg && !s_axi_bvalid;
	assign busy = (state_reg != S_IDLE);
	assign start = awHeld_reg && wHeld_reg && !s_axi_bvalid && !busy &&
		awAddr_reg == tmsc_pkg::OFS_WORD && wStrb_reg[2:0] == 3'h7;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			awHeld_reg <= 1'b0;
			wHeld_reg <= 1'b0;
			awAddr_reg <= 4'h0;
			wData_reg <= 32'h0000_0000;
			wStrb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= tmsc_pkg::RESP_OKAY;
			pins_reg <= tmsc_pkg::PINS_RESET;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_reg <= 1'b1;
				awAddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_reg <= 1'b1;
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
			end
			if (awHeld_reg && wHeld_reg && !s_axi_bvalid) begin
				awHeld_reg <= 1'b0;
				wHeld_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// Busy or partial word writes and unmapped offsets are refused
				s_axi_bresp <= (start || (awAddr_reg == tmsc_pkg::OFS_PINS)) ?
					tmsc_pkg::RESP_OKAY : tmsc_pkg::RESP_SLVERR;
				if (awAddr_reg == tmsc_pkg::OFS_PINS && wStrb_reg[0]) begin
					pins_reg <= wData_reg[7:0];
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read path, one cycle answer
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= tmsc_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= tmsc_mapped(s_axi_araddr) ? tmsc_pkg::RESP_OKAY : tmsc_pkg::RESP_SLVERR;
			case (s_axi_araddr)
				tmsc_pkg::OFS_WORD: s_axi_rdata <= {8'h00, word_reg};
				tmsc_pkg::OFS_STATUS: s_axi_rdata <= {29'h000_0000, programmed_reg,
					lockSync_reg, busy};
				tmsc_pkg::OFS_PINS: s_axi_rdata <= {24'h00_0000, pins_reg};
				default: s_axi_rdata <= 32'h0000_0000;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Lock pin comes from the far end: two flops before use
	always_ff @(posedge core_clk) begin
		lockMeta_reg <= link.freq_select1_or_lock_out;
		lockSync_reg <= lockMeta_reg;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Serial clock divider: tick every HALF_CYC cycles while shifting
	assign tick = busy && (divCnt_reg == 16'(HALF_CYC - 1));

	always_ff @(posedge core_clk) begin
		if (reset || !busy || tick) begin
			divCnt_reg <= 16'h0000;
		end else begin
			divCnt_reg <= divCnt_reg + 16'h0001;
		end
	end

	// Word goes out MSB first, strobe low throughout, raised after bit 0 R12 R21
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_reg <= S_IDLE;
			word_reg <= 24'h00_0000;
			bitIdx_reg <= 5'h00;
			serSclk_reg <= 1'b0;
			serData_reg <= 1'b0;
			serStrobe_reg <= 1'b0;
			programmed_reg <= 1'b0;
		end else begin
			case (state_reg)
				S_IDLE: begin
					if (start) begin
						word_reg <= wData_reg[23:0];
						bitIdx_reg <= 5'(tmsc_pkg::WORD_W - 1);
						serData_reg <= wData_reg[tmsc_pkg::WORD_W-1];
						serSclk_reg <= 1'b0;
						serStrobe_reg <= 1'b0; // R21
						state_reg <= S_LOW;
					end
				end
				S_LOW: if (tick) begin
					serSclk_reg <= 1'b1;
					state_reg <= S_HIGH;
				end
				S_HIGH: if (tick) begin
					serSclk_reg <= 1'b0;
					if (bitIdx_reg == 5'h00) begin
						state_reg <= S_LOAD;
					end else begin
						bitIdx_reg <= bitIdx_reg - 5'h01;
						serData_reg <= word_reg[bitIdx_reg - 5'h01];
						state_reg <= S_LOW;
					end
				end
				S_LOAD: if (tick) begin
					serStrobe_reg <= 1'b1; // R21
					state_reg <= S_HOLD;
				end
				S_HOLD: if (tick) begin
					programmed_reg <= 1'b1;
					state_reg <= S_IDLE;
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin drivers; strap levels until the first word, then the strobe on the first select pin; the enables carry the serial port only while busy.
	// The second select pin is released once programmed, as the far end
	// then drives lock onto it R2 R3
	always_ff @(posedge core_clk) begin
		if (reset) begin
			link.freq_select0_or_load_strobe <= 1'b0;
			link.fs1HostOut <= 1'b0;
			link.fs1HostOeN <= 1'b1;
			link.rxEnHost <= 1'b0;
			link.txEnHost <= 1'b0;
			link.ctlOeN <= 1'b1;
			link.modulation_select_pin <= 1'b0;
			link.lna_gain_pin <= 1'b0;
		end else begin
			link.freq_select0_or_load_strobe <= (busy || programmed_reg) ? serStrobe_reg :
				pins_reg[tmsc_pkg::PIN_FS0];
			link.fs1HostOut <= pins_reg[tmsc_pkg::PIN_FS1];
			link.fs1HostOeN <= !(pins_reg[tmsc_pkg::PIN_FS1_DRIVE] && !programmed_reg && !busy);
			link.rxEnHost <= busy ? serSclk_reg : pins_reg[tmsc_pkg::PIN_RE];
			link.txEnHost <= busy ? serData_reg : pins_reg[tmsc_pkg::PIN_TE];
			link.ctlOeN <= !(pins_reg[tmsc_pkg::PIN_CTL_DRIVE] || busy);
			link.modulation_select_pin <= pins_reg[tmsc_pkg::PIN_MOD];
			link.lna_gain_pin <= pins_reg[tmsc_pkg::PIN_GAIN];
		end
	end

endmodule : tmsc_host_end

`default_nettype wire

// ===== hdl/tmsc_pkg.sv
// Shared constants for the transceiver mode and serial configuration ends.
// Assumes both ends run on core_clk at 200 MHz and include nothing else.
`default_nettype none

package tmsc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Control word layout
	localparam int WORD_W = 24;
	localparam int DATA_W = 22;
	localparam int ADDR_HI = 23;
	localparam int ADDR_LO = 22;
	localparam int NUM_WORDS = 4;
	localparam int REF_W = 10;
	localparam int MAIN_W = 17;
	localparam int OPST_LSB = 10;
	localparam int LNA_BIT = 12;
	localparam int MOD_BIT = 19;
	localparam int VCO_LSB = 18;
	localparam int BAND_BIT = 17;

	// Latch address codes
	localparam logic [1:0] ADDR_RX_CTRL = 2'h0;
	localparam logic [1:0] ADDR_TX_OPTS = 2'h1;
	localparam logic [1:0] ADDR_RX_MAIN = 2'h2;
	localparam logic [1:0] ADDR_TX_MAIN = 2'h3;

	typedef enum logic [1:0] {
		OP_STANDBY = 2'h0,
		OP_RX = 2'h1,
		OP_TX = 2'h2,
		OP_IDLE = 2'h3
	} tmsc_op_type;

	typedef logic [NUM_WORDS-1:0][DATA_W-1:0] tmsc_words_type;

	////////////////////////////////////////////////////////////////////////////////
	// Strap defaults: fixed upper fields and per-channel dividers
	localparam logic [11:0] RX_CTRL_UPPER = 12'h07C;
	localparam logic [11:0] TX_OPTS_UPPER = 12'h73A;
	localparam logic [1:0] RX_MAIN_UPPER = 2'h0;
	localparam logic [4:0] TX_MAIN_UPPER = 5'h04;
	localparam logic [9:0] REF_16 = 10'h010;
	localparam logic [9:0] REF_32 = 10'h020;
	localparam logic [9:0] REF_18 = 10'h012;
	localparam logic [16:0] NR_1919 = 17'h0_077F;
	localparam logic [16:0] NT_1943 = 17'h0_0797;
	localparam logic [16:0] NR_1894 = 17'h0_0766;
	localparam logic [16:0] NT_1942 = 17'h0_0796;
	localparam logic [16:0] NR_4047 = 17'h0_0FCF;
	localparam logic [16:0] NT_4095 = 17'h0_0FFF;
	localparam logic [16:0] NR_766 = 17'h0_02FE;
	localparam logic [16:0] NT_793 = 17'h0_0319;

	// Default word set for select levels {second pin, first pin}
	function automatic tmsc_words_type tmsc_defaults(input logic [1:0] sel);
		logic band;
		logic [1:0] vco;
		logic [9:0] refDiv;
		logic [16:0] nRx;
		logic [16:0] nTx;
		tmsc_words_type w;
		case (sel)
			2'h0: begin
				band = 1'b1; vco = 2'h3; refDiv = REF_16; nRx = NR_1919; nTx = NT_1943;
			end
			2'h1: begin
				band = 1'b0; vco = 2'h1; refDiv = REF_32; nRx = NR_1894; nTx = NT_1942;
			end
			2'h2: begin
				band = 1'b1; vco = 2'h3; refDiv = REF_32; nRx = NR_4047; nTx = NT_4095;
			end
			default: begin
				band = 1'b0; vco = 2'h0; refDiv = REF_18; nRx = NR_766; nTx = NT_793;
			end
		endcase
		w[ADDR_RX_CTRL] = {RX_CTRL_UPPER, refDiv};
		w[ADDR_TX_OPTS] = {TX_OPTS_UPPER, refDiv};
		w[ADDR_RX_MAIN] = {RX_MAIN_UPPER, vco, band, nRx};
		w[ADDR_TX_MAIN] = {TX_MAIN_UPPER, nTx};
		return w;
	endfunction : tmsc_defaults

	////////////////////////////////////////////////////////////////////////////////
	// Host register map (AXI4-Lite, byte addresses)
	localparam int AXI_AW = 4;
	localparam logic [3:0] OFS_WORD = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_PINS = 4'h8;
	localparam logic [7:0] PINS_RESET = 8'h80;
	localparam int PIN_FS0 = 0;
	localparam int PIN_FS1 = 1;
	localparam int PIN_FS1_DRIVE = 2;
	localparam int PIN_RE = 3;
	localparam int PIN_TE = 4;
	localparam int PIN_MOD = 5;
	localparam int PIN_GAIN = 6;
	localparam int PIN_CTL_DRIVE = 7;
	localparam int ST_BUSY = 0;
	localparam int ST_LOCK = 1;
	localparam int ST_PROG = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Serial clock timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int SCLK_HALF_NS = 25;
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ARM_CYC = 3;

endpackage : tmsc_pkg

`default_nettype wire

// ===== hdl/tmsc_link_if.sv
// Pin-level link between the host controller and the transceiver control logic.
// Assumes the bench joins both modports; undriven pins resolve low here.
`default_nettype none

interface tmsc_link_if;
	logic freq_select0_or_load_strobe;
	logic fs1HostOut;
	logic fs1HostOeN;
	logic fs1DevOut;
	logic fs1DevOeN;
	logic rxEnHost;
	logic txEnHost;
	logic ctlOeN;
	logic modulation_select_pin;
	logic lna_gain_pin;
	logic freq_select1_or_lock_out;
	logic rx_enable_or_serial_clock;
	logic tx_enable_or_serial_data;

	// Shared pin: device wins once it drives, else host, else pull low
	assign freq_select1_or_lock_out = !fs1DevOeN ? fs1DevOut : (!fs1HostOeN ? fs1HostOut : 1'b0);
	// Internal pull-downs: released control pins read low R7
	assign rx_enable_or_serial_clock = ctlOeN ? 1'b0 : rxEnHost;
	assign tx_enable_or_serial_data = ctlOeN ? 1'b0 : txEnHost;

	modport device (
		input freq_select0_or_load_strobe,
		input freq_select1_or_lock_out,
		input rx_enable_or_serial_clock,
		input tx_enable_or_serial_data,
		input modulation_select_pin,
		input lna_gain_pin,
		output fs1DevOut,
		output fs1DevOeN
	);

	modport host (
		output freq_select0_or_load_strobe,
		output fs1HostOut,
		output fs1HostOeN,
		output rxEnHost,
		output txEnHost,
		output ctlOeN,
		output modulation_select_pin,
		output lna_gain_pin,
		input freq_select1_or_lock_out
	);
endinterface : tmsc_link_if

`default_nettype wire

// ===== hdl/tmsc_device_end.sv
// Transceiver control logic: strapped mode, programmable mode, three-wire port.
// Assumes pins arrive asynchronously and lockDetect comes from core_clk logic.
//
// How it works
// R1: Power-up starts strapped mode with pin-chosen defaults
// R2: Outside circuit ties both select pins fixed
// R3: Keep first select pin steady to stay strapped
// R4: Select 00 and 01 default divider sets
// R5: Select 10 and 11 default divider sets
// R6: Enable pins pick standby, receive, transmit, idle
// R7: Enable pins pulled low when undriven
// R8: Pins pick modulation type and LNA gain
// R9: First select-pin change enters programmable mode forever
// R10: Serial clock rise shifts data into register
// R11: Strobe rise copies register into one latch
// R12: Word is two address bits, 22 data, MSB first
// R13: Extra leading bits fall out; last 24 kept
// R14: Address codes 00..11 pick words one..four
// R15: Writing one word leaves others unchanged
// R16: Port works in standby and active states
// R17: State changes keep programmed settings
// R18: Programmable defaults frozen from pins before entry
// R19: Reference and main dividers sit at fixed fields
// R20: State field 11:10 encodes standby, rx, tx, idle
// R21: Host holds strobe low while shifting
// R22: Host writes ones into must-be-one bits
`default_nettype none

module tmsc_device_end (
	input wire logic core_clk,
	input wire logic reset,
	tmsc_link_if.device link,
	input wire logic lockDetect,
	output logic progMode,
	output logic progEntry,
	output logic wordLoaded,
	output logic [1:0] loadedAddr,
	output tmsc_pkg::tmsc_op_type opState,
	output logic modFsk,
	output logic lnaHighGain,
	output logic [9:0] rxRefDiv,
	output logic [9:0] txRefDiv,
	output logic [16:0] rxMainDiv,
	output logic [16:0] txMainDiv,
	output tmsc_pkg::tmsc_words_type ctlWords
);

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	localparam int NPIN = 6;
	localparam int P_FS0 = 0;
	localparam int P_FS1 = 1;
	localparam int P_RE = 2;
	localparam int P_TE = 3;
	localparam int P_MOD = 4;
	localparam int P_GAIN = 5;

	logic [NPIN-1:0] pinRaw;
	logic [NPIN-1:0] pinMeta_reg;
	logic [NPIN-1:0] pinSync_reg;
	logic [NPIN-1:0] pinPrev_reg;
	logic [1:0] armCnt_reg;
	logic armed;
	logic fs0Change;
	logic sclkRise;
	logic strobeRise;
	logic [tmsc_pkg::WORD_W-1:0] shift_reg;
	logic progMode_reg;
	logic [1:0] addrField;

	// Raw pin vector; undriven enables already resolve low R7
	assign pinRaw = {link.lna_gain_pin, link.modulation_select_pin,
		link.tx_enable_or_serial_data, link.rx_enable_or_serial_clock,
		link.freq_select1_or_lock_out, link.freq_select0_or_load_strobe};

	// Two flops per pin; edge logic reads only the second and later
	always_ff @(posedge core_clk) begin
		pinMeta_reg <= pinRaw;
		pinSync_reg <= pinMeta_reg;
		pinPrev_reg <= pinSync_reg;
	end

	// Hold off change detection until the synchroniser holds real levels
	always_ff @(posedge core_clk) begin
		if (reset) begin
			armCnt_reg <= 2'h0;
		end else if (!armed) begin
			armCnt_reg <= armCnt_reg + 2'h1;
		end
	end

	assign armed = (armCnt_reg == 2'(tmsc_pkg::ARM_CYC));

	// The select pin doubles as strobe: any change leaves strapped mode R9
	assign fs0Change = armed && (pinSync_reg[P_FS0] != pinPrev_reg[P_FS0]);
	assign sclkRise = armed && pinSync_reg[P_RE] && !pinPrev_reg[P_RE];
	assign strobeRise = armed && pinSync_reg[P_FS0] && !pinPrev_reg[P_FS0];

	////////////////////////////////////////////////////////////////////////////////
	// Mode tracking

	// Reset is power-up: strapped mode first, programmable mode is sticky R1 R9
	always_ff @(posedge core_clk) begin
		if (reset) begin
			progMode_reg <= 1'b0;
		end else if (fs0Change) begin
			progMode_reg <= 1'b1; // R9
		end
	end

	assign progMode = progMode_reg;

	// One-cycle pulse at the moment programmable mode is taken
	always_ff @(posedge core_clk) begin
		if (reset) begin
			progEntry <= 1'b0;
		end else begin
			progEntry <= fs0Change && !progMode_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Three-wire shift register

	// Shifts in every mode; strapped-mode enable toggles are harmless
	// because only the last full word before a strobe matters
	always_ff @(posedge core_clk) begin
		if (reset) begin
			shift_reg <= '0;
		end else if (sclkRise) begin
			shift_reg <= {shift_reg[tmsc_pkg::WORD_W-2:0], pinSync_reg[P_TE]}; // R10 R12 R13
		end
	end

	assign addrField = shift_reg[tmsc_pkg::ADDR_HI:tmsc_pkg::ADDR_LO]; // R12

	////////////////////////////////////////////////////////////////////////////////
	// Control word latches

	// Strapped mode tracks the pin defaults; the entry edge freezes the
	// levels seen just before it, and a rising entry edge also loads R18
	always_ff @(posedge core_clk) begin
		if (reset) begin
			ctlWords <= tmsc_pkg::tmsc_defaults(2'h0);
		end else if (strobeRise && (progMode_reg || fs0Change)) begin
			ctlWords[addrField] <= shift_reg[tmsc_pkg::DATA_W-1:0]; // R11 R14 R15 R16
		end else if (!progMode_reg && !fs0Change) begin
			ctlWords <= tmsc_pkg::tmsc_defaults({pinPrev_reg[P_FS1],
				pinPrev_reg[P_FS0]}); // R1 R4 R5
		end
	end

	// Load report for the user side, raised on the same edge that updates the latch
	always_ff @(posedge core_clk) begin
		if (reset) begin
			wordLoaded <= 1'b0;
			loadedAddr <= 2'h0;
		end else begin
			wordLoaded <= strobeRise && (progMode_reg || fs0Change);
			if (strobeRise) begin
				loadedAddr <= addrField;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Operating state, modulation and gain

	// Pins rule in strapped mode, word fields in programmable mode; a state
	// change never touches the latches, so settings persist R17
	always_ff @(posedge core_clk) begin
		if (reset) begin
			opState <= tmsc_pkg::OP_STANDBY;
			modFsk <= 1'b0;
			lnaHighGain <= 1'b1;
		end else if (!progMode_reg) begin
			opState <= tmsc_pkg::tmsc_op_type'({pinSync_reg[P_TE], pinSync_reg[P_RE]}); // R6
			modFsk <= pinSync_reg[P_MOD]; // R8
			lnaHighGain <= !pinSync_reg[P_GAIN]; // R8
		end else begin
			opState <= tmsc_pkg::tmsc_op_type'(ctlWords[tmsc_pkg::ADDR_RX_CTRL]
				[tmsc_pkg::OPST_LSB+1:tmsc_pkg::OPST_LSB]); // R20 R17
			modFsk <= ctlWords[tmsc_pkg::ADDR_RX_CTRL][tmsc_pkg::MOD_BIT];
			lnaHighGain <= ctlWords[tmsc_pkg::ADDR_RX_CTRL][tmsc_pkg::LNA_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Divider fields

	// Straight slices of the latch flops
	assign rxRefDiv = ctlWords[tmsc_pkg::ADDR_RX_CTRL][tmsc_pkg::REF_W-1:0]; // R19
	assign txRefDiv = ctlWords[tmsc_pkg::ADDR_TX_OPTS][tmsc_pkg::REF_W-1:0]; // R19
	assign rxMainDiv = ctlWords[tmsc_pkg::ADDR_RX_MAIN][tmsc_pkg::MAIN_W-1:0]; // R19
	assign txMainDiv = ctlWords[tmsc_pkg::ADDR_TX_MAIN][tmsc_pkg::MAIN_W-1:0]; // R19

	////////////////////////////////////////////////////////////////////////////////
	// Lock indication on the shared second select pin

	// Driven only in programmable mode, so a strapped level is never fought
	always_ff @(posedge core_clk) begin
		if (reset) begin
			link.fs1DevOut <= 1'b0;
			link.fs1DevOeN <= 1'b1;
		end else begin
			link.fs1DevOut <= lockDetect;
			link.fs1DevOeN <= !progMode_reg;
		end
	end

endmodule : tmsc_device_end

`default_nettype wire

// ===== testbench/tmsc_link_checker.sv
// Pin-level assertions on the link between host and device ends.
// Assumes core_clk samples every pin and reset is the device reset.
`default_nettype none

module tmsc_link_checker (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic freq_select0_or_load_strobe,
	input wire logic rx_enable_or_serial_clock,
	input wire logic tx_enable_or_serial_data,
	input wire logic fs1DevOeN
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	logic [5:0] bitCnt;
	wire logic strobe = freq_select0_or_load_strobe;
	wire logic sclk = rx_enable_or_serial_clock;
	wire logic sdata = tx_enable_or_serial_data;

	////////////////////////////////////////////////////////////////
	// Serial clock rises since the strobe last fell; wraps harmlessly in strap mode
	always_ff @(posedge core_clk) begin
		if (reset || $fell(strobe))
			bitCnt <= '0;
		else if ($rose(sclk))
			bitCnt <= bitCnt + 6'h01;
	end

	a_strap_start: assert property ($fell(reset) |-> fs1DevOeN [*3])
		else $error("lock drive active right after reset");
	a_prog_sticky: assert property (!fs1DevOeN |=> !fs1DevOeN)
		else $error("programmable mode left without reset");
	a_prog_entry: assert property ($changed(strobe) && fs1DevOeN |-> ##[1:8] !fs1DevOeN)
		else $error("strobe change did not enter programmable mode");
	a_strobe_idle: assert property ($rose(sclk) && !fs1DevOeN |-> !strobe)
		else $error("serial clock rose with strobe high");
	a_strobe_clk_low: assert property ($rose(strobe) && !fs1DevOeN |-> !sclk)
		else $error("strobe rose with serial clock high");
	a_word_bits: assert property ($rose(strobe) && !fs1DevOeN |-> bitCnt == 6'h18)
		else $error("word not 24 serial clocks long");
	a_data_hold: assert property (sclk && $past(sclk) && !fs1DevOeN |-> $stable(sdata))
		else $error("serial data moved while clock high");
	a_clk_high_len: assert property ($rose(sclk) && !fs1DevOeN |-> sclk [*2])
		else $error("serial clock high phase too short");
endmodule : tmsc_link_checker

`default_nettype wire

// ===== testbench/transceiver_mode_and_serial_config_tb.sv
// Self-checking bench: host end drives device end over the pin link.
// Assumes HALF_CYC of 2 and a device reset that the bench can pulse alone.
`default_nettype none

module transceiver_mode_and_serial_config_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic devHold = 1'b0;
	logic lockDetect = 1'b0;
	wire logic devReset = reset | devHold;
	logic [3:0] awaddr = 4'h0;
	logic [3:0] araddr = 4'h0;
	logic [31:0] wdata = 32'h0000_0000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, progMode, modFsk, lnaHighGain;
	logic [1:0] bresp, rresp, loadedAddr;
	logic [31:0] rdata;
	logic [9:0] rxRefDiv, txRefDiv;
	logic [16:0] rxMainDiv, txMainDiv;
	tmsc_pkg::tmsc_op_type opState;
	tmsc_pkg::tmsc_words_type ctlWords;
	int mismatches = 0;
	int compares = 0;
	int loads = 0, entries = 0;
	logic wordLoaded, progEntry;
	logic [21:0] mdl [4];
	logic [23:0] sent [$];
	logic [9:0] refT [4] = '{10'h010, 10'h020, 10'h020, 10'h012};
	logic [16:0] nrT [4] = '{17'h0_077F, 17'h0_0766, 17'h0_0FCF, 17'h0_02FE};
	logic [16:0] ntT [4] = '{17'h0_0797, 17'h0_0796, 17'h0_0FFF, 17'h0_0319};
	logic [1:0] vcoT [4] = '{2'h3, 2'h1, 2'h3, 2'h0};

	tmsc_link_if link ();
	tmsc_device_end tmsc_device_end_inst (.core_clk(core_clk), .reset(devReset), .link(link),
		.lockDetect(lockDetect), .progMode(progMode), .progEntry(progEntry), .wordLoaded(wordLoaded),
		.loadedAddr(loadedAddr), .opState(opState), .modFsk(modFsk), .lnaHighGain(lnaHighGain),
		.rxRefDiv(rxRefDiv), .txRefDiv(txRefDiv), .rxMainDiv(rxMainDiv),
		.txMainDiv(txMainDiv), .ctlWords(ctlWords));
	tmsc_host_end #(.HALF_CYC(2)) tmsc_host_end_inst (.core_clk(core_clk), .reset(reset),
		.link(link), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	tmsc_link_checker tmsc_link_checker_inst (.core_clk(core_clk), .reset(devReset),
		.freq_select0_or_load_strobe(link.freq_select0_or_load_strobe),
		.rx_enable_or_serial_clock(link.rx_enable_or_serial_clock),
		.tx_enable_or_serial_data(link.tx_enable_or_serial_data), .fs1DevOeN(link.fs1DevOeN));

	////////////////////////////////////////////////////////////////
	// Clock and a watchdog far beyond the expected few thousand cycles
	always #2.5 core_clk = ~core_clk;

	// Load and entry reports last one cycle, so count them at every edge
	always @(posedge core_clk) begin
		loads <= loads + int'(wordLoaded === 1'b1);
		entries <= entries + int'(progEntry === 1'b1);
	end
	initial begin
		#100000;
		mismatches++;
		results();
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// Write holds each channel until its own ready, response held until seen
	task automatic axiWr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge core_clk);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
			if (bvalid === 1'b1)
				break;
		end
		check(bresp, tmsc_pkg::RESP_OKAY);
		bready <= 1'b0;
	endtask : axiWr

	task automatic axiRd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge core_clk);
			if (arready === 1'b1)
				arvalid <= 1'b0;
			if (rvalid === 1'b1)
				break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : axiRd

	task automatic compareAll();
		check(rxRefDiv, mdl[0][9:0]);
		check(txRefDiv, mdl[1][9:0]);
		check(rxMainDiv, mdl[2][16:0]);
		check(txMainDiv, mdl[3][16:0]);
		for (int k = 0; k < 4; k++)
			check(ctlWords[k], mdl[k]);
	endtask : compareAll

	task automatic results();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results

	////////////////////////////////////////////////////////////////
	// Straps per channel, then programmable mode and word traffic
	initial begin
		logic [31:0] rd;
		logic [1:0] r, sv, mg;
		logic [23:0] w;
		int seed, n;
		repeat (12) @(posedge core_clk);
		reset <= 1'b0;
		lockDetect <= 1'b1;
		seed = $urandom(32);
		// Device reset alone lets a changed first select pin count as a strap
		for (int s = 0; s < 4; s++) begin
			sv = 2'(s);
			mg = 2'($urandom);
			axiWr(tmsc_pkg::OFS_PINS, 32'({1'b1, mg, sv, 1'b1, sv}));
			repeat (8) @(posedge core_clk);
			devHold <= 1'b1;
			repeat (4) @(posedge core_clk);
			devHold <= 1'b0;
			repeat (14) @(posedge core_clk);
			mdl[0] = {tmsc_pkg::RX_CTRL_UPPER, refT[s]};
			mdl[1] = {tmsc_pkg::TX_OPTS_UPPER, refT[s]};
			mdl[2] = {tmsc_pkg::RX_MAIN_UPPER, vcoT[s], !sv[0], nrT[s]};
			mdl[3] = {tmsc_pkg::TX_MAIN_UPPER, ntT[s]};
			check(progMode, 1'b0);
			compareAll();
			check(opState, sv);
			check(modFsk, mg[0]);
			check(lnaHighGain, !mg[1]);
		end
		// Released enables must read low through the pull-downs
		axiWr(tmsc_pkg::OFS_PINS, 32'h0000_001F);
		repeat (12) @(posedge core_clk);
		check(opState, tmsc_pkg::OP_STANDBY);
		// One stray leading bit, pushed out by the first full word
		axiWr(tmsc_pkg::OFS_PINS, 32'h0000_009F);
		axiWr(tmsc_pkg::OFS_PINS, 32'h0000_0080);
		repeat (12) @(posedge core_clk);
		check(progMode, 1'b1);
		compareAll();
		check(entries, 4);
		for (int i = 0; i < 12; i++) begin
			w = {2'(i), 22'($urandom)};
			w[13] = (w[23:22] == 2'h0) ? 1'b1 : w[13];
			w[20] = (w[23:22] == 2'h1) ? 1'b1 : w[20];
			sent.push_back(w);
			n = loads;
			axiWr(tmsc_pkg::OFS_WORD, 32'(w));
			do
				axiRd(tmsc_pkg::OFS_STATUS, rd, r);
			while (rd[0] === 1'b1);
			check(rd[2:0], 3'h6);
			repeat (10) @(posedge core_clk);
			w = sent.pop_front();
			mdl[w[23:22]] = w[21:0];
			compareAll();
			check(loadedAddr, w[23:22]);
			check(opState, mdl[0][11:10]);
			check({modFsk, lnaHighGain}, {mdl[0][19], mdl[0][12]});
			check(loads, n + 1);
			axiRd(tmsc_pkg::OFS_WORD, rd, r);
			check(rd[23:0], w);
		end
		axiRd(4'hC, rd, r);
		check(r, tmsc_pkg::RESP_SLVERR);
		check(rd, 32'h0000_0000);
		results();
	end
endmodule : transceiver_mode_and_serial_config_tb

`default_nettype wire
